// *** core/ddr_cmd_if.sv ***
// Command bus between memory controller and refresh-mode device end
`timescale 1ns/10ps
interface ddr_cmd_if;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bg0;
    logic [2:0]  ba_sel;
    logic [13:0] addr;

    modport ctrl (output cs_n, act_n, ras_n, cas_n, we_n, bg0, ba_sel, addr);
    modport dev  (input  cs_n, act_n, ras_n, cas_n, we_n, bg0, ba_sel, addr);
endinterface : ddr_cmd_if

// *** core/fgr_controller.sv ***
// Controller end: issues mode set and refresh commands on the link
`timescale 1ns/10ps
module fgr_controller
    import fgr_pkg::*;
#(
    parameter int DENSITY = 1
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    ddr_cmd_if.ctrl            cmd,
    input  wire logic          mode_req,
    input  wire logic [2:0]    mode_value,
    input  wire logic          tcr_enable,
    input  wire logic          ref_req,
    input  wire logic          ref_high_rate,
    output logic               req_busy,
    output logic               req_reject
);
    import fgr_pkg::*;

    localparam logic [15:0] RFC1_CYC = 16'(ns_to_cyc(RFC1_NS[DENSITY]));
    localparam logic [15:0] RFC2_CYC = 16'(ns_to_cyc(RFC2_NS[DENSITY]));
    localparam logic [15:0] RFC4_CYC = 16'(ns_to_cyc(RFC4_NS[DENSITY]));

    logic [2:0]  mode;
    logic [2:0]  next_mode;
    logic [15:0] wait_cnt;
    logic [15:0] next_wait_cnt;
    logic        next_req_busy;
    logic        next_req_reject;
    logic        next_cs_n;
    logic        next_we_n;
    logic        next_bg0;
    logic [13:0] next_addr;
    logic        mode_ok;
    logic [15:0] rfc_sel;

    // Legal field value check
    always_comb begin
        case (mode_value)
            MODE_FIXED_1X: mode_ok = 1'b1;
            MODE_FIXED_2X, MODE_FIXED_4X,
            MODE_OTF_1X2X, MODE_OTF_1X4X: mode_ok = !tcr_enable;
            default: mode_ok = 1'b0;
        endcase
        // Cycle time of the refresh we would send now
        case (mode)
            MODE_FIXED_2X: rfc_sel = RFC2_CYC;
            MODE_FIXED_4X: rfc_sel = RFC4_CYC;
            MODE_OTF_1X2X: rfc_sel = ref_high_rate ? RFC2_CYC : RFC1_CYC;
            MODE_OTF_1X4X: rfc_sel = ref_high_rate ? RFC4_CYC : RFC1_CYC;
            default:       rfc_sel = RFC1_CYC;
        endcase
    end

    // Command issue and wait timer
    always_comb begin
        next_mode = mode;
        next_wait_cnt = wait_cnt;
        next_req_reject = 1'b0;
        next_cs_n = 1'b1; // Deselect by default
        next_we_n = 1'b1;
        next_bg0 = 1'b0;
        next_addr = 14'h0000;
        if (wait_cnt != 16'h0000) begin
            next_wait_cnt = wait_cnt - 16'h0001;
            next_req_reject = ref_req || mode_req;
        end else if (mode_req) begin
            if (mode_ok) begin
                next_cs_n = 1'b0;
                next_we_n = 1'b0;
                next_addr[MR3_MODE_MSB:MR3_MODE_LSB] = mode_value;
                next_mode = mode_value;
                next_wait_cnt = 16'h0001;
            end else begin
                next_req_reject = 1'b1;
            end
        end else if (ref_req) begin
            next_cs_n = 1'b0;
            next_bg0 = mode[2] && ref_high_rate;
            next_wait_cnt = rfc_sel;
        end
        next_req_busy = next_wait_cnt != 16'h0000;
    end

    // Registered command pins and state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
            wait_cnt <= 16'h0000;
            req_busy <= 1'b0;
            req_reject <= 1'b0;
            cmd.cs_n <= 1'b1;
            cmd.we_n <= 1'b1;
            cmd.bg0 <= 1'b0;
            cmd.addr <= 14'h0000;
        end else begin
            mode <= next_mode;
            wait_cnt <= next_wait_cnt;
            req_busy <= next_req_busy;
            req_reject <= next_req_reject;
            cmd.cs_n <= next_cs_n;
            cmd.we_n <= next_we_n;
            cmd.bg0 <= next_bg0;
            cmd.addr <= next_addr;
        end
    end

    // Fixed command fields
    assign cmd.act_n = 1'b1;
    assign cmd.ras_n = 1'b0;
    assign cmd.cas_n = 1'b0;
    assign cmd.ba_sel = MR3_SELECT;
endmodule : fgr_controller

// *** core/fgr_device.sv ***
// Device end: refresh mode register and refresh qualification
`timescale 1ns/10ps
module fgr_device
    import fgr_pkg::*;
#(
    parameter int DENSITY = 1
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    ddr_cmd_if.dev             cmd,
    input  wire logic [1:0]    temp_band,
    output fgr_pkg::rate_t     active_rate,
    output logic [2:0]         refresh_mode,
    output logic               refresh_busy,
    output logic               refresh_done,
    output logic               rate_error,
    output logic [15:0]        interval_cyc,
    output logic [15:0]        cycle_cyc
);
    import fgr_pkg::*;

    localparam logic [15:0] RFC1_CYC = 16'(ns_to_cyc(RFC1_NS[DENSITY]));
    localparam logic [15:0] RFC2_CYC = 16'(ns_to_cyc(RFC2_NS[DENSITY]));
    localparam logic [15:0] RFC4_CYC = 16'(ns_to_cyc(RFC4_NS[DENSITY]));
    localparam logic [15:0] REFI_CYC = 16'(REFI_BASE_CYC);

    logic        is_ref;
    logic        is_mrs;
    logic        on_the_fly_rate_select;
    rate_t       cmd_rate;
    logic        legal;
    logic [15:0] rfc_of;
    logic [2:0]  next_refresh_mode;
    rate_t       next_active_rate;
    logic        next_refresh_busy;
    logic        next_refresh_done;
    logic        next_rate_error;
    logic [15:0] next_interval_cyc;
    logic [15:0] next_cycle_cyc;
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;

    // Command decode
    assign is_ref = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n
                    && cmd.we_n;
    assign is_mrs = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n
                    && !cmd.we_n && cmd.ba_sel == MR3_SELECT;

    // Rate chosen by mode field and BG0
    always_comb begin
        on_the_fly_rate_select = refresh_mode[2];
        cmd_rate = RATE_1X;
        legal = 1'b1;
        case (refresh_mode)
            MODE_FIXED_1X: cmd_rate = RATE_1X;
            MODE_FIXED_2X: cmd_rate = RATE_2X;
            MODE_FIXED_4X: cmd_rate = RATE_4X;
            MODE_OTF_1X2X: cmd_rate = (on_the_fly_rate_select && cmd.bg0) ? RATE_2X : RATE_1X;
            MODE_OTF_1X4X: cmd_rate = (on_the_fly_rate_select && cmd.bg0) ? RATE_4X : RATE_1X;
            default:       legal = 1'b0;
        endcase
    end

    // Cycle time of the chosen rate
    always_comb begin
        case (cmd_rate)
            RATE_2X: rfc_of = RFC2_CYC;
            RATE_4X: rfc_of = RFC4_CYC;
            default: rfc_of = RFC1_CYC;
        endcase
    end

    // Next state of mode, rate, timers and flags
    always_comb begin
        next_refresh_mode = refresh_mode;
        next_active_rate = active_rate;
        next_refresh_busy = refresh_busy;
        next_refresh_done = 1'b0;
        next_rate_error = 1'b0;
        next_cycle_cyc = cycle_cyc;
        next_busy_cnt = busy_cnt;
        if (busy_cnt != 16'h0000) begin
            next_busy_cnt = busy_cnt - 16'h0001;
            if (busy_cnt == 16'h0001) begin
                next_refresh_busy = 1'b0;
                next_refresh_done = 1'b1;
            end
            if (!cmd.cs_n) begin
                next_rate_error = 1'b1;
            end
        end else if (is_mrs) begin
            next_refresh_mode = cmd.addr[MR3_MODE_MSB:MR3_MODE_LSB];
        end else if (is_ref) begin
            if (!legal) begin
                next_rate_error = 1'b1;
            end else begin
                next_active_rate = cmd_rate;
                next_cycle_cyc = rfc_of;
                next_busy_cnt = rfc_of;
                next_refresh_busy = 1'b1;
            end
        end
        // Interval halves per rate step and temperature band
        case (next_active_rate)
            // Shift widened to three bits so band 3 plus a step cannot wrap
            RATE_2X: next_interval_cyc =
                REFI_CYC >> ({1'b0, temp_band} + 3'h1);
            RATE_4X: next_interval_cyc =
                REFI_CYC >> ({1'b0, temp_band} + 3'h2);
            default: next_interval_cyc = REFI_CYC >> temp_band;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            refresh_mode <= MODE_RESET;
            active_rate <= RATE_1X;
            refresh_busy <= 1'b0;
            refresh_done <= 1'b0;
            rate_error <= 1'b0;
            interval_cyc <= REFI_CYC;
            cycle_cyc <= RFC1_CYC;
            busy_cnt <= 16'h0000;
        end else begin
            refresh_mode <= next_refresh_mode;
            active_rate <= next_active_rate;
            refresh_busy <= next_refresh_busy;
            refresh_done <= next_refresh_done;
            rate_error <= next_rate_error;
            interval_cyc <= next_interval_cyc;
            cycle_cyc <= next_cycle_cyc;
            busy_cnt <= next_busy_cnt;
        end
    end
endmodule : fgr_device

// *** core/fgr_pkg.sv ***
// Shared constants and types for the fine granularity refresh link
package fgr_pkg;
    // Refresh mode field codes
    typedef enum logic [2:0] {
        MODE_FIXED_1X = 3'h0,
        MODE_FIXED_2X = 3'h1,
        MODE_FIXED_4X = 3'h2,
        MODE_OTF_1X2X = 3'h5,
        MODE_OTF_1X4X = 3'h6
    } refresh_mode_t;

    // Refresh rate of one command
    typedef enum logic [1:0] {
        RATE_1X = 2'h0,
        RATE_2X = 2'h1,
        RATE_4X = 2'h2
    } rate_t;

    // Mode register 3 field placement
    localparam int MR3_MODE_LSB = 6;
    localparam int MR3_MODE_MSB = 8;
    localparam logic [2:0] MR3_SELECT = 3'h3;
    localparam logic [2:0] MODE_RESET = 3'h0;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int REFI_BASE_NS = 7800;
    localparam int REFI_BASE_CYC = REFI_BASE_NS / CLK_PERIOD_NS;
    // Density index: 0=2Gb 1=4Gb 2=8Gb 3=16Gb
    localparam int RFC1_NS [4] = '{160, 260, 350, 350};
    localparam int RFC2_NS [4] = '{110, 160, 260, 260};
    localparam int RFC4_NS [4] = '{90, 110, 160, 160};
    // Temperature band 0..3 halves the interval each step
    localparam int TEMP_BANDS = 4;

    // Least time rounds up to whole cycles
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
endpackage : fgr_pkg

// *** tb/fgr_asserts.sv ***
// Wire checks on the command link between controller and device ends
`timescale 1ns/10ps
module fgr_asserts
    import fgr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        act_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        bg0,
    input wire logic [2:0]  ba_sel,
    input wire logic [13:0] addr
);
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic       refr;
    logic       mrs;
    logic       r2x;
    logic       r4x;

    // Decode commands and the rate each refresh runs at
    assign refr = !cs_n && we_n;
    assign mrs  = !cs_n && !we_n;
    assign r2x  = refr && (mode == MODE_FIXED_2X
                  || (mode == MODE_OTF_1X2X && bg0));
    assign r4x  = refr && (mode == MODE_FIXED_4X
                  || (mode == MODE_OTF_1X4X && bg0));

    // Mirror of the mode field as last written on the link
    always_comb begin
        next_mode = mode;
        if (!rst_n) next_mode = MODE_RESET;
        else if (mrs) next_mode = addr[8:6];
    end
    always_ff @(posedge clk_sys) begin
        mode <= next_mode;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_ref_code; !cs_n |-> act_n && !ras_n && !cas_n; endproperty
    property p_mrs_sel; mrs |-> ba_sel == MR3_SELECT; endproperty
    property p_no_rsvd;
        mrs |-> addr[8:6] inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    endproperty
    property p_rst_idle; $rose(rst_n) |-> cs_n; endproperty
    property p_mrs_gap; mrs |=> cs_n; endproperty
    // Deselect counts match the 4Gb cycle times at 50 ns
    property p_gap1; refr && !r2x && !r4x |=> cs_n [*6]; endproperty
    property p_gap2; r2x |=> cs_n [*4]; endproperty
    property p_gap4; r4x |=> cs_n [*3]; endproperty

    a_ref_code: assert property (p_ref_code)
        else $error("Command encoding wrong");
    a_mrs_sel: assert property (p_mrs_sel)
        else $error("Mode set aimed at wrong register");
    a_no_rsvd: assert property (p_no_rsvd)
        else $error("Reserved refresh mode written");
    a_rst_idle: assert property (p_rst_idle)
        else $error("Command issued at reset release");
    a_mrs_gap: assert property (p_mrs_gap)
        else $error("Command right after mode set");
    a_gap1: assert property (p_gap1)
        else $error("Command inside normal refresh cycle");
    a_gap2: assert property (p_gap2)
        else $error("Command inside double refresh cycle");
    a_gap4: assert property (p_gap4)
        else $error("Command inside quad refresh cycle");

    c_otf2x: cover property (r2x && mode == MODE_OTF_1X2X);
    c_otf4x: cover property (r4x && mode == MODE_OTF_1X4X);
    c_mrs: cover property (mrs);
endmodule : fgr_asserts

// *** tb/fine_granularity_refresh_mode_bench.sv ***
// Bench: controller end driving device end over the command link
`timescale 1ns/10ps
module fine_granularity_refresh_mode_bench;
    import fgr_pkg::*;
    localparam int P = CLK_PERIOD_NS - 1;
    localparam int CY [3] = '{(RFC1_NS[1] + P) / CLK_PERIOD_NS,
        (RFC2_NS[1] + P) / CLK_PERIOD_NS, (RFC4_NS[1] + P) / CLK_PERIOD_NS};
    logic        clk_sys = 0, rst_n = 0, mode_req = 0, tcr_enable = 0;
    logic        ref_req = 0, ref_high_rate = 0, req_busy, req_reject;
    logic [2:0]  mode_value = 0, refresh_mode, cur_mode = 0;
    logic [1:0]  temp_band = 0;
    logic        refresh_busy, refresh_done, rate_error;
    logic        err_seen = 0, rej_seen = 0, wire_bg0 = 0;
    logic [15:0] interval_cyc, cycle_cyc;
    rate_t       active_rate;
    int          fail_count = 0, cmp_count = 0, ref_cnt = 0, k, n0;

    ddr_cmd_if bus ();
    fgr_controller #(.DENSITY(1)) i_fgr_controller (.clk_sys(clk_sys),
        .rst_n(rst_n), .cmd(bus.ctrl), .mode_req(mode_req),
        .mode_value(mode_value), .tcr_enable(tcr_enable),
        .ref_req(ref_req), .ref_high_rate(ref_high_rate),
        .req_busy(req_busy), .req_reject(req_reject));
    fgr_device #(.DENSITY(1)) i_fgr_device (.clk_sys(clk_sys),
        .rst_n(rst_n), .cmd(bus.dev), .temp_band(temp_band),
        .active_rate(active_rate), .refresh_mode(refresh_mode),
        .refresh_busy(refresh_busy), .refresh_done(refresh_done),
        .rate_error(rate_error), .interval_cyc(interval_cyc),
        .cycle_cyc(cycle_cyc));
    fgr_asserts i_fgr_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
        .cs_n(bus.cs_n), .act_n(bus.act_n), .ras_n(bus.ras_n),
        .cas_n(bus.cas_n), .we_n(bus.we_n), .bg0(bus.bg0),
        .ba_sel(bus.ba_sel), .addr(bus.addr));

    always #25 clk_sys = ~clk_sys;

    // Catch pulses and refresh commands seen on the link
    always @(posedge clk_sys) begin
        if (rate_error === 1'b1) err_seen = 1;
        if (req_reject === 1'b1) rej_seen = 1;
        if (bus.cs_n === 1'b0 && bus.we_n === 1'b1) begin
            ref_cnt++;
            wire_bg0 = bus.bg0;
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // Bounded wait for a level; n returns the cycles spent
    task automatic wait_lvl(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v) begin
            tick(1);
            n++;
            if (n > 40) begin
                chk("wait", 16'(v), 16'(s));
                print_verdict();
            end
        end
    endtask : wait_lvl

    task automatic set_mode(input logic [2:0] v, input logic t, rej);
        wait_lvl(req_busy, 0, k);
        rej_seen = 0;
        mode_value = v;
        tcr_enable = t;
        mode_req = 1;
        tick(1);
        mode_req = 0;
        tick(3);
        chk("mode_reject", 16'(rej), 16'(rej_seen));
        if (!rej) cur_mode = v;
    endtask : set_mode

    task automatic do_ref(input logic hi, input rate_t r);
        wait_lvl(req_busy, 0, k);
        ref_high_rate = hi;
        ref_req = 1;
        tick(1);
        ref_req = 0;
        wait_lvl(refresh_busy, 1, k);
        chk("active_rate", 16'(r), 16'(active_rate));
        // BG0 is only driven high in the on-the-fly codes
        chk("bg0", 16'(hi && cur_mode[2]), 16'(wire_bg0));
        wait_lvl(refresh_busy, 0, k);
        chk("busy_cycles", 16'(CY[r]), 16'(k));
        chk("cycle_cyc", 16'(CY[r]), cycle_cyc);
        chk("interval", 16'(REFI_BASE_CYC >> (int'(temp_band) + int'(r))),
            interval_cyc);
        chk("rate_error", 0, 16'(err_seen));
    endtask : do_ref

    initial begin
        tick(6);
        rst_n = 1;
        tick(1);
        chk("reset_mode", 0, 16'(refresh_mode));
        chk("reset_rate", 0, 16'(active_rate));
        chk("reset_interval", 16'(REFI_BASE_CYC), interval_cyc);
        chk("reset_cycle", 16'(CY[0]), cycle_cyc);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            set_mode(3'(i), 0, 0);
            chk("mode", 16'(i), 16'(refresh_mode));
            do_ref(i != 0, rate_t'(i));
            do_ref(i != 0, rate_t'(i));
        end
        $display("test fixed done");
        set_mode(MODE_OTF_1X2X, 0, 0);
        do_ref(0, RATE_1X);
        do_ref(1, RATE_2X);
        set_mode(MODE_OTF_1X4X, 0, 0);
        do_ref(1, RATE_4X);
        do_ref(0, RATE_1X);
        $display("test on_the_fly done");
        for (int b = 0; b < TEMP_BANDS; b++) begin
            temp_band = 2'(b);
            do_ref(1, RATE_4X);
        end
        temp_band = 0;
        $display("test temperature done");
        set_mode(3'h3, 0, 1);
        chk("mode_kept", 16'(MODE_OTF_1X4X), 16'(refresh_mode));
        set_mode(MODE_FIXED_2X, 1, 1);
        set_mode(MODE_FIXED_1X, 1, 0);
        rej_seen = 0;
        n0 = ref_cnt;
        ref_high_rate = 0;
        ref_req = 1;
        tick(2);
        ref_req = 0;
        wait_lvl(refresh_busy, 0, k);
        tick(CY[0]);
        chk("busy_reject", 1, 16'(rej_seen));
        chk("ref_count", 1, 16'(ref_cnt - n0));
        $display("test refusals done");
        print_verdict();
    end
endmodule : fine_granularity_refresh_mode_bench
